// ---- common/flash_host_pkg.sv ----
// constants, types and register map of the parallel flash host controller
// assumes a 250 MHz system clock and a flash part wired pin for pin
package flash_host_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WE_LOW_NS = 50;
    localparam int T_READ_ACC_NS = 100;
    localparam int T_RECOVER_NS = 30;
    localparam int T_RESET_WAIT_US = 10;
    localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_ACC_CYC = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_WAIT_CYC = (T_RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int CFG_WORD_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_POLL_OK_BIT = 1;
    localparam int STAT_POLL_ERR_BIT = 2;
    localparam int STAT_REFUSED_BIT = 3;
    localparam logic CFG_WORD_RESET = 1'b0;

    // ------------------------------------------------------------
    // flash command set
    // ------------------------------------------------------------
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] RESET_CMD = 16'h00f0;
    localparam logic [15:0] IDENT_CMD = 16'h0090;
    localparam logic [18:0] UNLOCK1_ADDR_BYTE = 19'h0aaaa;
    localparam logic [18:0] UNLOCK1_ADDR_WORD = 19'h05555;
    localparam logic [18:0] UNLOCK2_ADDR_BYTE = 19'h05555;
    localparam logic [18:0] UNLOCK2_ADDR_WORD = 19'h02aaa;
    localparam int ERROR_BIT = 5;
    localparam logic [15:0] DQ_OE_BYTE_WR = 16'h80ff;
    localparam logic [15:0] DQ_OE_BYTE_RD = 16'h8000;
    localparam logic [15:0] DQ_OE_WORD_WR = 16'hffff;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_RESET, OP_IDENT, OP_UNLOCK_CMD, OP_POLL
    } flash_op_type;

    typedef struct packed {
        logic [17:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic byte_n;
        logic [15:0] dq;
        logic [15:0] dq_oe;
    } flash_pins_type;

    typedef struct packed {
        logic wr;
        logic last;
        logic [18:0] addr;
        logic [15:0] data;
    } bus_cycle_type;

endpackage

// ---- rtl/flash_host.sv ----
// host controller driving a parallel flash through its strobes and pins
// assumes software on Avalon-MM and flash inputs synchronous to i_clk_sys
//
// Function
// - host ends operation when two consecutive reads match; next read is final.
// - first unlock cycle writes AAh to AAAAh byte-wide, 5555h word-wide.
// - second unlock cycle writes 55h to 5555h byte-wide, 2AAAh word-wide.
// - after read/reset during erase host waits 10us before trusting reads.
// - identify mode entered by unlock pair then 90h at first unlock address.
`timescale 1ns/100ps
module flash_host (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [15:0] i_flash_dq,
    output flash_host_pkg::flash_pins_type o_flash
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOVER, S_SETTLE} state_type;

    state_type state_reg, state_next;
    flash_op_type op_reg, op_next;
    flash_pins_type pins_reg, pins_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [1:0] step_reg, step_next;
    logic busy_reg, busy_next;
    logic word_reg, word_next;
    logic [18:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [15:0] rdata_reg, rdata_next;
    logic [15:0] prev_reg, prev_next;
    logic have_prev_reg, have_prev_next;
    logic final_reg, final_next;
    logic poll_ok_reg, poll_ok_next;
    logic poll_err_reg, poll_err_next;
    logic repeat_reg, repeat_next;
    logic refused_reg, refused_next;
    logic wait_reg, wait_next;
    logic [31:0] avs_rd_reg, avs_rd_next;
    bus_cycle_type cyc;
    logic [15:0] captured;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // command sequences
    // ------------------------------------------------------------
    function automatic bus_cycle_type step_cycle(flash_op_type op, logic [1:0] step,
                                                 logic word, logic [18:0] a, logic [15:0] d);
        bus_cycle_type c;
        c = '{wr: 1'b1, last: 1'b0, addr: a, data: d};
        if (op == OP_READ || op == OP_POLL) begin
            c.wr = 1'b0;
            c.last = 1'b1;
        end else if (op == OP_WRITE) begin
            c.last = 1'b1;
        end else if (step == 2'd0) begin
            c.addr = word ? UNLOCK1_ADDR_WORD : UNLOCK1_ADDR_BYTE;
            c.data = UNLOCK1_DATA;
        end else if (step == 2'd1) begin
            c.addr = word ? UNLOCK2_ADDR_WORD : UNLOCK2_ADDR_BYTE;
            c.data = UNLOCK2_DATA;
        end else begin
            c.last = 1'b1;
            if (op == OP_RESET) begin
                c.data = RESET_CMD;
            end else if (op == OP_IDENT) begin
                c.addr = word ? UNLOCK1_ADDR_WORD : UNLOCK1_ADDR_BYTE;
                c.data = IDENT_CMD;
            end
        end
        return c;
    endfunction

    function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign cyc = step_cycle(op_reg, step_reg, word_reg, addr_reg, wdata_reg);
    assign captured = word_reg ? i_flash_dq : {8'h00, i_flash_dq[7:0]};

    always_comb begin
        unique case (i_avs_address)
            OFS_CTRL: rd_mux = {29'h0, op_reg};
            OFS_CFG: rd_mux = {31'h0, word_reg};
            OFS_ADDR: rd_mux = {13'h0, addr_reg};
            OFS_WDATA: rd_mux = {16'h0, wdata_reg};
            OFS_RDATA: rd_mux = {16'h0, rdata_reg};
            OFS_STATUS: rd_mux = {28'h0, refused_reg, poll_err_reg, poll_ok_reg, busy_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] merged;
        merged = 32'h0;
        state_next = state_reg;
        op_next = op_reg;
        pins_next = pins_reg;
        cnt_next = cnt_reg;
        step_next = step_reg;
        busy_next = busy_reg;
        word_next = word_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        prev_next = prev_reg;
        have_prev_next = have_prev_reg;
        final_next = final_reg;
        poll_ok_next = poll_ok_reg;
        poll_err_next = poll_err_reg;
        repeat_next = repeat_reg;
        refused_next = refused_reg;
        wait_next = wait_reg;
        avs_rd_next = avs_rd_reg;

        // bus slave: one wait cycle, effect at the edge with waitrequest low
        if ((i_avs_read || i_avs_write) && wait_reg) begin
            wait_next = 1'b0;
            avs_rd_next = i_avs_read ? rd_mux : 32'h0;
        end else if ((i_avs_read || i_avs_write) && !wait_reg) begin
            wait_next = 1'b1;
            if (i_avs_write) begin
                unique case (i_avs_address)
                    OFS_CTRL: begin
                        if (i_avs_byteenable[0]) begin
                            if (busy_reg || i_avs_writedata[2:0] > 3'(OP_POLL)) begin
                                refused_next = 1'b1;
                            end else begin
                                op_next = flash_op_type'(i_avs_writedata[2:0]);
                                busy_next = 1'b1;
                                step_next = 2'd0;
                                have_prev_next = 1'b0;
                                final_next = 1'b0;
                                poll_ok_next = 1'b0;
                                poll_err_next = 1'b0;
                                state_next = S_SETUP;
                            end
                        end
                    end
                    OFS_CFG: begin
                        if (!busy_reg && i_avs_byteenable[0]) begin
                            word_next = i_avs_writedata[CFG_WORD_BIT];
                        end
                    end
                    OFS_ADDR: begin
                        merged = be_merge({13'h0, addr_reg}, i_avs_writedata, i_avs_byteenable);
                        addr_next = merged[18:0];
                    end
                    OFS_WDATA: begin
                        merged = be_merge({16'h0, wdata_reg}, i_avs_writedata, i_avs_byteenable);
                        wdata_next = merged[15:0];
                    end
                    OFS_STATUS: begin
                        if (i_avs_byteenable[0] && i_avs_writedata[STAT_REFUSED_BIT]) begin
                            refused_next = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        // a refusal in this very cycle beats the software clear
        if (i_avs_write && !wait_reg && i_avs_address == OFS_CTRL && i_avs_byteenable[0]
            && (busy_reg || i_avs_writedata[2:0] > 3'(OP_POLL))) begin
            refused_next = 1'b1;
        end

        // flash bus cycle engine
        unique case (state_reg)
            S_IDLE: begin
            end
            S_SETUP: begin
                pins_next.ce_n = 1'b0;
                pins_next.byte_n = word_reg;
                pins_next.addr = word_reg ? cyc.addr[17:0] : cyc.addr[18:1];
                pins_next.dq = word_reg ? cyc.data : {cyc.addr[0], 7'h00, cyc.data[7:0]};
                if (cyc.wr) begin
                    pins_next.dq_oe = word_reg ? DQ_OE_WORD_WR : DQ_OE_BYTE_WR;
                    pins_next.we_n = 1'b0;
                end else begin
                    pins_next.dq_oe = word_reg ? 16'h0000 : DQ_OE_BYTE_RD;
                    pins_next.oe_n = 1'b0;
                end
                cnt_next = 12'h0;
                state_next = S_STROBE;
            end
            S_STROBE: begin
                cnt_next = cnt_reg + 12'h1;
                if ((cyc.wr && cnt_reg == 12'(WE_LOW_CYC - 1))
                    || (!cyc.wr && cnt_reg == 12'(READ_ACC_CYC - 1))) begin
                    pins_next.we_n = 1'b1;
                    pins_next.oe_n = 1'b1;
                    cnt_next = 12'h0;
                    state_next = S_RECOVER;
                    repeat_next = 1'b0;
                    if (!cyc.wr) begin
                        rdata_next = captured;
                        prev_next = captured;
                        have_prev_next = 1'b1;
                    end
                    if (!cyc.wr && op_reg == OP_POLL) begin
                        repeat_next = 1'b1;
                        if (final_reg) begin
                            repeat_next = 1'b0;
                            poll_ok_next = 1'b1;
                        end else if (have_prev_reg && captured == prev_reg) begin
                            final_next = 1'b1;
                        end else if (have_prev_reg && captured[ERROR_BIT]
                                     && prev_reg[ERROR_BIT]) begin
                            repeat_next = 1'b0;
                            poll_err_next = 1'b1;
                        end
                    end
                end
            end
            S_RECOVER: begin
                pins_next.ce_n = 1'b1;
                pins_next.dq_oe = 16'h0000;
                cnt_next = cnt_reg + 12'h1;
                if (cnt_reg == 12'(RECOVER_CYC - 1)) begin
                    cnt_next = 12'h0;
                    if (!cyc.last) begin
                        step_next = step_reg + 2'd1;
                        state_next = S_SETUP;
                    end else if (repeat_reg) begin
                        state_next = S_SETUP;
                    end else if (op_reg == OP_RESET) begin
                        state_next = S_SETTLE;
                    end else begin
                        busy_next = 1'b0;
                        state_next = S_IDLE;
                    end
                end
            end
            S_SETTLE: begin
                cnt_next = cnt_reg + 12'h1;
                if (cnt_reg == 12'(RESET_WAIT_CYC - 1)) begin
                    busy_next = 1'b0;
                    state_next = S_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= S_IDLE;
            op_reg <= OP_READ;
            pins_reg <= '{addr: 18'h0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b0,
                          dq: 16'h0, dq_oe: 16'h0};
            cnt_reg <= 12'h0;
            step_reg <= 2'd0;
            busy_reg <= 1'b0;
            word_reg <= CFG_WORD_RESET;
            addr_reg <= 19'h0;
            wdata_reg <= 16'h0;
            rdata_reg <= 16'h0;
            prev_reg <= 16'h0;
            have_prev_reg <= 1'b0;
            final_reg <= 1'b0;
            poll_ok_reg <= 1'b0;
            poll_err_reg <= 1'b0;
            repeat_reg <= 1'b0;
            refused_reg <= 1'b0;
            wait_reg <= 1'b1;
            avs_rd_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            pins_reg <= pins_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
            busy_reg <= busy_next;
            word_reg <= word_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            prev_reg <= prev_next;
            have_prev_reg <= have_prev_next;
            final_reg <= final_next;
            poll_ok_reg <= poll_ok_next;
            poll_err_reg <= poll_err_next;
            repeat_reg <= repeat_next;
            refused_reg <= refused_next;
            wait_reg <= wait_next;
            avs_rd_reg <= avs_rd_next;
        end
    end

    assign o_flash = pins_reg;
    assign o_avs_readdata = avs_rd_reg;
    assign o_avs_waitrequest = wait_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    AST_UNLOCK1: assert property ($fell(pins_reg.we_n) && op_reg inside {OP_RESET, OP_IDENT,
        OP_UNLOCK_CMD} && step_reg == 2'd0 |-> pins_reg.dq[7:0] == 8'haa
        && (word_reg ? pins_reg.addr == 18'h05555
                     : {pins_reg.addr[15:0], pins_reg.dq[15]} == 17'h0aaaa))
        else $error("first unlock cycle has wrong address or data");
    AST_UNLOCK2: assert property ($fell(pins_reg.we_n) && op_reg inside {OP_RESET, OP_IDENT,
        OP_UNLOCK_CMD} && step_reg == 2'd1 |-> pins_reg.dq[7:0] == 8'h55
        && (word_reg ? pins_reg.addr == 18'h02aaa
                     : {pins_reg.addr[15:0], pins_reg.dq[15]} == 17'h05555))
        else $error("second unlock cycle has wrong address or data");
    AST_IDENT_CMD: assert property ($fell(pins_reg.we_n) && op_reg == OP_IDENT
        && step_reg == 2'd2 |-> pins_reg.dq[7:0] == 8'h90
        && $past(step_reg, 8) == 2'd1)
        else $error("identify command not after unlock pair or wrong data");
    AST_RESET_WAIT: assert property ($fell(busy_reg) && op_reg == OP_RESET
        |-> $past(state_reg) == S_SETTLE && $past(cnt_reg) == 12'(RESET_WAIT_CYC - 1))
        else $error("read/reset finished without its settle wait");
    AST_POLL_MATCH: assert property ($rose(final_reg)
        |-> $past(have_prev_reg) && prev_reg == $past(prev_reg))
        else $error("poll declared stable without two equal reads");
    COV_RESET: cover property ($fell(busy_reg) && op_reg == OP_RESET);
    COV_POLL_OK: cover property ($rose(poll_ok_reg));
    COV_IDENT: cover property ($fell(busy_reg) && op_reg == OP_IDENT);
endmodule

// ---- testbench/flash_model.sv ----
// behavioural flash part: unlock, reset, identify and program with status reads
// assumes the host pins of flash_pins_type; it answers on the strobes, no clock
`timescale 1ns/100ps
module flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h0031, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h00c4, // arbitrary value
    parameter int BUSY_READS = 3
) (
    input wire flash_host_pkg::flash_pins_type i_flash,
    output logic [15:0] o_dq
);
    import flash_host_pkg::*;
    logic [15:0] mem [256];
    logic [1:0] stage = 2'd0;
    logic pend = 1'b0, ident = 1'b0, busy = 1'b0, err = 1'b0, tog = 1'b0;
    logic ers = 1'b0, sus = 1'b0, esu = 1'b0, tg2 = 1'b0;
    logic [5:0] eb = 6'd0;
    int left = 0;
    logic [15:0] pd = 16'h0000;
    logic [7:0] pa = 8'h00;
    logic [7:0] d;
    logic [15:0] key, rd_val;
    logic ua1, ua2;
    // ----------------------------------------
    // command decode on the write strobe
    // ----------------------------------------
    assign key = i_flash.byte_n ? {1'b0, i_flash.addr[14:0]}
                                : {i_flash.addr[14:0], i_flash.dq[15]};
    assign ua1 = key == (i_flash.byte_n ? 16'h5555 : 16'haaaa);
    assign ua2 = key == (i_flash.byte_n ? 16'h2aaa : 16'h5555);
    initial foreach (mem[i]) mem[i] = 16'hffff;
    always @(posedge i_flash.we_n) begin
        if (!i_flash.ce_n) begin
            d = i_flash.dq[7:0];
            if (busy) begin
                if (d == 8'hf0) begin
                    busy = 1'b0;
                    err = 1'b0;
                    ers = 1'b0;
                    sus = 1'b0;
                end
                if (ers && d == 8'hb0) sus = 1'b1;
                if (ers && d == 8'h30) sus = 1'b0;
            end else if (pend) begin
                pend = 1'b0;
                pa = i_flash.addr[7:0];
                pd = i_flash.dq;
                err = |(i_flash.dq & ~mem[pa]);
                busy = 1'b1;
                left = BUSY_READS;
            end else if (stage == 2'd1) begin
                stage = (ua2 && d == 8'h55) ? 2'd2 : 2'd0;
            end else if (stage == 2'd2) begin
                stage = 2'd0;
                ident = ua1 && d == 8'h90;
                pend = d == 8'ha0;
                if (esu && d == 8'h30) begin
                    busy = 1'b1;
                    ers = 1'b1;
                    eb = i_flash.addr[17:12];
                    left = 2 * BUSY_READS;
                    err = 1'b0;
                end
                esu = d == 8'h80;
                if (d == 8'hf0) err = 1'b0;
            end else begin
                stage = (ua1 && d == 8'haa) ? 2'd1 : 2'd0;
                if (!(ua1 && d == 8'haa)) ident = 1'b0;
                if (d == 8'hf0) err = 1'b0;
            end
        end
    end
    // ----------------------------------------
    // read side: status, identify or array
    // ----------------------------------------
    always @(negedge i_flash.oe_n) begin
        if (!i_flash.ce_n && busy) begin
            if (!sus) tog = ~tog;
            if (ers && i_flash.addr[17:12] == eb) tg2 = ~tg2;
            if (!err && !sus) left = left - 1;
            if (left == 0) begin
                busy = 1'b0;
                if (!ers) mem[pa] = pd;
                else if (eb != 6'd0) foreach (mem[i]) mem[i] = 16'hffff;
                ers = 1'b0;
            end
        end
    end
    always @* begin
        if (busy && sus) begin
            rd_val = mem[i_flash.addr[7:0]];
            if (i_flash.addr[17:12] == eb) begin
                rd_val = {8'h00, 2'b11, err, 2'b01, tg2, 2'b00};
            end
        end else if (busy && ers) begin
            rd_val = {8'h00, 1'b0, tog, err, 2'b01, 1'b1, 2'b00};
            if (i_flash.addr[17:12] == eb) rd_val[2] = tg2;
        end else if (busy) rd_val = {8'h00, ~pd[7], tog, err, 5'b00100};
        else if (ident) begin
            case (i_flash.addr[1:0])
                2'd0: rd_val = MAKER_CODE;
                2'd1: rd_val = DEVICE_CODE;
                2'd2: rd_val = {15'h0000, i_flash.addr[17:12] == 6'd0};
                default: rd_val = 16'h0000;
            endcase
        end else rd_val = mem[i_flash.addr[7:0]];
    end
    // released bus shows the inverse, never the last value
    assign o_dq = (!i_flash.ce_n && !i_flash.oe_n) ? rd_val : ~rd_val;
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the flash host: registers, identify, reset, program, poll
// assumes flash_model on the pins and the design's one-wait-cycle register bus
`timescale 1ns/100ps
module testbench;
    import flash_host_pkg::*;
    localparam logic [15:0] MAKER = 16'h0031; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h00c4; // arbitrary value
    localparam int CEIL = 40000;
    logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, rd = 1'b0, wr = 1'b0, wait_req;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, avs_rdata;
    logic [15:0] mdq, fdq;
    flash_pins_type pins;
    int err_total = 0, tests_run = 0, cycles = 0;
    always #2 i_clk_sys = ~i_clk_sys;
    assign fdq = (pins.dq & pins.dq_oe) | (mdq & ~pins.dq_oe);
    flash_host i_flash_host (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(wait_req),
        .i_flash_dq(fdq), .o_flash(pins));
    flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_READS(3)) i_flash_model (
        .i_flash(pins), .o_dq(mdq));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do @(posedge i_clk_sys); while (wait_req !== 1'b0);
        rdat = avs_rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic wait_idle();
        repeat (2000) begin
            access(1'b0, OFS_STATUS, 32'h0);
            if (rdat[STAT_BUSY_BIT] === 1'b0) return;
        end
        err_total++;
        $display("[ERR] %0t flash operation never finished", $time);
        conclude();
    endtask
    task automatic run(input logic [2:0] op);
        access(1'b1, OFS_CTRL, {29'h0, op});
        wait_idle();
    endtask
    task automatic read_at(input logic [18:0] a);
        access(1'b1, OFS_ADDR, {13'h0, a});
        run(OP_READ);
        access(1'b0, OFS_RDATA, 32'h0);
    endtask
    task automatic cmd(input logic [15:0] c, input logic [18:0] a);
        access(1'b1, OFS_WDATA, {16'h0, c});
        access(1'b1, OFS_ADDR, {13'h0, a});
        run(OP_UNLOCK_CMD);
    endtask
    task automatic program_word(input logic [15:0] v);
        cmd(16'h00a0, 19'h00010);
        access(1'b1, OFS_WDATA, {16'h0, v});
        run(OP_WRITE);
        run(OP_POLL);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        access(1'b0, OFS_CFG, 32'h0);
        check(rdat, {31'h0, CFG_WORD_RESET}, "cfg reset");
        access(1'b0, 8'h40, 32'h0);
        check(rdat, 32'h0, "unmapped read");
        access(1'b1, OFS_CTRL, 32'h7);
        access(1'b0, OFS_STATUS, 32'h0);
        check(rdat[STAT_REFUSED_BIT], 1'b1, "refused flag");
        access(1'b1, OFS_STATUS, 32'h8);
        access(1'b0, OFS_STATUS, 32'h0);
        check(rdat, 32'h0, "status clear");
        access(1'b1, OFS_CTRL, {29'h0, OP_RESET});
        access(1'b1, OFS_CTRL, 32'h0);
        access(1'b1, OFS_CFG, 32'h1);
        access(1'b0, OFS_STATUS, 32'h0);
        check(rdat, 32'h9, "refused while busy");
        wait_idle();
        access(1'b0, OFS_CFG, 32'h0);
        check(rdat, 32'h0, "cfg kept while busy");
        access(1'b1, OFS_STATUS, 32'h8);
    endtask
    task automatic t_ident();
        run(OP_IDENT);
        read_at(19'h0);
        check(rdat, {24'h0, MAKER[7:0]}, "maker code");
        read_at(19'h2);
        check(rdat, {24'h0, DEVICE[7:0]}, "device code");
        read_at(19'h4);
        check(rdat, 32'h1, "protected block");
        read_at(19'h2004);
        check(rdat, 32'h0, "open block");
        run(OP_RESET);
        read_at(19'h0);
        check(rdat, 32'hff, "array after reset");
    endtask
    task automatic t_program();
        access(1'b1, OFS_CFG, 32'h1);
        program_word(16'h1234);
        check(rdat[2:1], 2'b01, "poll ok");
        access(1'b0, OFS_RDATA, 32'h0);
        check(rdat, 32'h1234, "final poll value");
        program_word(16'h00ff);
        check(rdat[STAT_POLL_ERR_BIT], 1'b1, "poll error");
        run(OP_RESET);
        read_at(19'h10);
        check(rdat, 32'h1234, "array after failed program");
    endtask
    task automatic t_erase();
        logic [31:0] first;
        cmd(16'h0080, 19'h01000);
        cmd(16'h0030, 19'h01000);
        read_at(19'h01010);
        first = rdat;
        check(rdat[7], 1'b0, "polling low in erase");
        read_at(19'h01010);
        check(rdat[6] ^ first[6], 1'b1, "primary toggle in erase");
        check(rdat[2] ^ first[2], 1'b1, "secondary toggle in erase");
        read_at(19'h00010);
        check(rdat[2], 1'b1, "secondary high off block");
        access(1'b1, OFS_WDATA, 32'hb0);
        run(OP_WRITE);
        read_at(19'h00010);
        check(rdat, 32'h1234, "array data in suspend");
        read_at(19'h01010);
        check(rdat[7:6], 2'b11, "suspended block status");
        access(1'b1, OFS_WDATA, 32'h30);
        run(OP_WRITE);
        run(OP_POLL);
        check(rdat[2:0], 3'b010, "erase poll ok");
        access(1'b0, OFS_RDATA, 32'h0);
        check(rdat, 32'hffff, "erased value");
    endtask
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        t_regs();
        t_ident();
        t_program();
        t_erase();
        conclude();
    end
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            err_total++;
            $display("[ERR] %0t run did not finish in time", $time);
            conclude();
        end
    end
endmodule
